// ---- hdl/dpss_regs.sv ----
`timescale 1ns/100ps
module dpss_regs
	import dpss_pkg::*;
#(
	parameter int unsigned LANES        = 4,
	parameter logic [7:0]  PROTO_MAJOR  = 8'h01, // arbitrary value
	parameter logic [7:0]  PROTO_MINOR  = 8'h00, // arbitrary value
	parameter logic [7:0]  PROTO_REV    = 8'h00, // arbitrary value
	parameter int unsigned VSYNC_CYCLES = VSYNC_DMA_CYCLES
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	// register bus, APB style
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [ADDR_W-1:0]   paddr_i,
	input  wire logic [DATA_W-1:0]   pwdata_i,
	output logic      [DATA_W-1:0]   prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// transceiver status, from the PHY domain
	input  wire logic [3:0]          transceiver_reset_control_done_i,
	input  wire logic [1:0]          phy_tile_pll_lock_i,
	input  wire logic                phy_fabric_pll_lock_i,
	input  wire logic                phy_rx_clk_lock_i,
	input  wire logic [3:0]          phy_prbs_err_i,
	input  wire logic [3:0]          phy_volt_low_i,
	input  wire logic [LANES-1:0]    phy_lane_align_i,
	input  wire logic [LANES-1:0]    phy_symbol_lock_i,
	input  wire logic [2*LANES-1:0]  phy_rx_buf_status_i,
	input  wire logic                phy_elec_idle_i,
	// video path events, from the video domain
	input  wire logic                pix_fifo_ovf_toggle_i,
	input  wire logic                vsync_level_i,
	input  wire logic                vsync_start_toggle_i,
	input  wire logic                dma_mode_i,
	// controls toward the core
	output logic      [DATA_W-1:0]   link_rate_o,
	output logic      [DATA_W-1:0]   lane_count_o,
	output logic                     phy_rx_reset_o
);

	localparam int unsigned SYNC_W = 21 + 4 * LANES;
	localparam logic [1:0]  ARM_DONE = 2'h3;
	localparam int unsigned VCNT_W = $clog2(VSYNC_CYCLES + 1);
	localparam logic [VCNT_W-1:0] VSYNC_LAST = VCNT_W'(VSYNC_CYCLES - 1);

	initial begin
		if (LANES != 4) begin
			$error("dpss_regs: status layout serves exactly four lanes");
		end
		if (VSYNC_CYCLES < 1) begin
			$error("dpss_regs: VSYNC_CYCLES must be at least 1");
		end
	end

	// reset release through two flip-flops
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	// all foreign-domain inputs share one synchroniser bank
	logic [SYNC_W-1:0] async_bus;
	logic [SYNC_W-1:0] sync_bus;

	assign async_bus = {
		phy_rx_buf_status_i,
		phy_symbol_lock_i,
		phy_lane_align_i,
		phy_volt_low_i,
		phy_prbs_err_i,
		phy_rx_clk_lock_i,
		phy_fabric_pll_lock_i,
		phy_tile_pll_lock_i,
		transceiver_reset_control_done_i,
		phy_elec_idle_i,
		pix_fifo_ovf_toggle_i,
		vsync_level_i,
		vsync_start_toggle_i,
		dma_mode_i
	};

	dpss_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.async_i (async_bus),
		.sync_o  (sync_bus)
	);

	logic        dma_mode_s;
	logic        vs_start_tgl_s;
	logic        vsync_level_s;
	logic        ovf_tgl_s;
	logic        elec_idle_s;
	logic [SYNC_W-6:0] transceiver_status_s;

	assign dma_mode_s     = sync_bus[0];
	assign vs_start_tgl_s = sync_bus[1];
	assign vsync_level_s  = sync_bus[2];
	assign ovf_tgl_s      = sync_bus[3];
	assign elec_idle_s    = sync_bus[4];
	assign transceiver_status_s   = sync_bus[SYNC_W-1:5];

	// event recovery from toggles; edge compares synced copy with a third stage
	logic ovf_tgl_reg;
	logic ovf_tgl_next;
	logic vs_tgl_reg;
	logic vs_tgl_next;
	logic ovf_event;
	logic vs_start_event;
	// toggles keep their level across our reset; edges are ignored until the
	// synchroniser and edge stage have refilled, so an event in that gap is lost
	logic [1:0] arm_reg;
	logic [1:0] arm_next;
	logic       armed;

	assign armed = (arm_reg == ARM_DONE);

	always_comb begin
		ovf_tgl_next   = ovf_tgl_s;
		vs_tgl_next    = vs_start_tgl_s;
		arm_next       = arm_reg;
		if (!armed) begin
			arm_next = arm_reg + 2'h1;
		end
		ovf_event      = armed && (ovf_tgl_s ^ ovf_tgl_reg);
		vs_start_event = armed && (vs_start_tgl_s ^ vs_tgl_reg);
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ovf_tgl_reg <= 1'b0;
			vs_tgl_reg  <= 1'b0;
			arm_reg     <= 2'h0;
		end else begin
			ovf_tgl_reg <= ovf_tgl_next;
			vs_tgl_reg  <= vs_tgl_next;
			arm_reg     <= arm_next;
		end
	end

	// bus access decode: one wait state, answer on the cycle after setup+enable
	logic access;
	logic wr_access;
	logic rd_access;

	assign access    = psel_i && penable_i && !pready_o;
	assign wr_access = access && pwrite_i;
	assign rd_access = access && !pwrite_i;

	// writable registers
	logic [DATA_W-1:0] link_rate_reg;
	logic [DATA_W-1:0] link_rate_next;
	logic [DATA_W-1:0] lane_count_reg;
	logic [DATA_W-1:0] lane_count_next;
	logic [DATA_W-1:0] xcvr_reset_reg;
	logic [DATA_W-1:0] xcvr_reset_next;
	logic [DATA_W-1:0] idle_reset_reg;
	logic [DATA_W-1:0] idle_reset_next;

	always_comb begin
		link_rate_next  = link_rate_reg;
		lane_count_next = lane_count_reg;
		xcvr_reset_next = xcvr_reset_reg;
		idle_reset_next = idle_reset_reg;
		if (wr_access) begin
			unique case (paddr_i)
				ADDR_LINK_RATE: begin
					link_rate_next = pwdata_i;
				end
				ADDR_LANE_COUNT: begin
					lane_count_next = pwdata_i;
				end
				ADDR_XCVR_RESET: begin
					xcvr_reset_next = pwdata_i;
				end
				ADDR_IDLE_RESET: begin
					idle_reset_next = pwdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_rate_reg  <= LINK_RATE_RST;
			lane_count_reg <= LANE_COUNT_RST;
			xcvr_reset_reg <= XCVR_RESET_RST;
			idle_reset_reg <= IDLE_RESET_RST;
		end else begin
			link_rate_reg  <= link_rate_next;
			lane_count_reg <= lane_count_next;
			xcvr_reset_reg <= xcvr_reset_next;
			idle_reset_reg <= idle_reset_next;
		end
	end

	// pixel FIFO overrun flag
	logic ovf_flag_reg;
	logic ovf_flag_next;

	always_comb begin
		ovf_flag_next = ovf_flag_reg;
		if (rd_access && paddr_i == ADDR_FIFO_OVERRUN) begin
			ovf_flag_next = 1'b0;
		end
		if (ovf_event) begin
			ovf_flag_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ovf_flag_reg <= 1'b0;
		end else begin
			ovf_flag_reg <= ovf_flag_next;
		end
	end

	// vertical sync monitor; dma pulse is rebuilt here at fixed length
	dpss_vs_state_type vs_state_reg;
	dpss_vs_state_type vs_state_next;
	logic [VCNT_W-1:0] vs_cnt_reg;
	logic [VCNT_W-1:0] vs_cnt_next;
	logic              vs_mon_reg;
	logic              vs_mon_next;

	always_comb begin
		vs_state_next = vs_state_reg;
		vs_cnt_next   = vs_cnt_reg;
		unique case (vs_state_reg)
			DPSS_VS_IDLE: begin
				if (dma_mode_s && vs_start_event) begin
					vs_state_next = DPSS_VS_DMA_PULSE;
					vs_cnt_next   = '0;
				end
			end
			DPSS_VS_DMA_PULSE: begin
				if (vs_cnt_reg == VSYNC_LAST) begin
					vs_state_next = DPSS_VS_IDLE;
				end else begin
					vs_cnt_next = vs_cnt_reg + VCNT_W'(1);
				end
			end
			default: begin
				vs_state_next = DPSS_VS_IDLE;
			end
		endcase
		if (dma_mode_s) begin
			vs_mon_next = (vs_state_next == DPSS_VS_DMA_PULSE);
		end else begin
			vs_mon_next = vsync_level_s;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vs_state_reg <= DPSS_VS_IDLE;
			vs_cnt_reg   <= '0;
			vs_mon_reg   <= 1'b0;
		end else begin
			vs_state_reg <= vs_state_next;
			vs_cnt_reg   <= vs_cnt_next;
			vs_mon_reg   <= vs_mon_next;
		end
	end

	// transceiver status word
	logic [DATA_W-1:0] xcvr_status;

	always_comb begin
		xcvr_status = '0;
		xcvr_status[ST_RESET_DONE_LSB +: 4] = transceiver_status_s[3:0];
		xcvr_status[ST_PLL_T0_BIT]     = transceiver_status_s[4];
		xcvr_status[ST_PLL_T1_BIT]     = transceiver_status_s[5];
		xcvr_status[ST_FABRIC_PLL_BIT] = transceiver_status_s[6];
		xcvr_status[ST_RXCLK_LOCK_BIT] = transceiver_status_s[7];
		xcvr_status[ST_PRBS_LSB +: 4] = transceiver_status_s[11:8];
		xcvr_status[ST_VOLT_LOW_LSB +: 4] = transceiver_status_s[15:12];
		xcvr_status[ST_ALIGN_LSB +: 2] = transceiver_status_s[17:16];
		// symbol lock, lane 1 at bit 20
		xcvr_status[ST_SYMLOCK_LSB +: 4] = transceiver_status_s[23:20];
		xcvr_status[ST_RXBUF_LSB +: 8] = sync_bus[SYNC_W-1 -: 8];
	end

	// read data and answer
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic              pready_reg;
	logic              pready_next;
	logic              pslverr_reg;
	logic              pslverr_next;
	logic              addr_hit;

	always_comb begin
		addr_hit     = 1'b1;
		prdata_next  = '0;
		unique case (paddr_i)
			ADDR_LINK_RATE: begin
				prdata_next = link_rate_reg;
			end
			ADDR_LANE_COUNT: begin
				prdata_next = lane_count_reg;
			end
			ADDR_BLOCK_ID: begin
				prdata_next = {PROTO_MAJOR, PROTO_MINOR, PROTO_REV, MODE_RECEIVE};
			end
			ADDR_FIFO_OVERRUN: begin
				prdata_next[0] = ovf_flag_reg;
			end
			ADDR_VSYNC_MON: begin
				prdata_next[0] = vs_mon_reg;
			end
			ADDR_XCVR_RESET: begin
				prdata_next = xcvr_reset_reg;
			end
			ADDR_XCVR_STATUS: begin
				prdata_next = xcvr_status;
			end
			ADDR_IDLE_RESET: begin
				prdata_next = idle_reset_reg;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
		if (!rd_access) begin
			prdata_next = '0;
		end
		pready_next  = access;
		pslverr_next = access && !addr_hit;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;

	// transceiver_reset_control output; idle reset only helps when no link is present
	logic phy_rst_reg;
	logic phy_rst_next;

	always_comb begin
		phy_rst_next = 1'b0;
		// hold code keeps phy in reset
		if (xcvr_reset_reg[1:0] == XCVR_HOLD_CODE) begin
			phy_rst_next = 1'b1;
		end
		if (idle_reset_reg[0] && elec_idle_s) begin
			phy_rst_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phy_rst_reg <= 1'b1;
		end else begin
			phy_rst_reg <= phy_rst_next;
		end
	end

	assign phy_rx_reset_o = phy_rst_reg;
	assign link_rate_o    = link_rate_reg;
	assign lane_count_o   = lane_count_reg;

endmodule

// ---- hdl/dpss_pkg.sv ----
package dpss_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// register byte addresses
	localparam logic [11:0] ADDR_LINK_RATE   = 12'h09C;
	localparam logic [11:0] ADDR_LANE_COUNT  = 12'h0A0;
	localparam logic [11:0] ADDR_BLOCK_ID    = 12'h0FC;
	localparam logic [11:0] ADDR_FIFO_OVERRUN = 12'h110;
	localparam logic [11:0] ADDR_VSYNC_MON   = 12'h114;
	localparam logic [11:0] ADDR_XCVR_RESET  = 12'h200;
	localparam logic [11:0] ADDR_XCVR_STATUS = 12'h208;
	localparam logic [11:0] ADDR_IDLE_RESET  = 12'h20C;

	// reset values and the transceiver hold code
	localparam logic [31:0] XCVR_RESET_RST  = 32'h00000003;
	localparam logic [1:0]  XCVR_HOLD_CODE  = 2'h3;
	localparam logic [31:0] LINK_RATE_RST   = 32'h00000000;
	localparam logic [31:0] LANE_COUNT_RST  = 32'h00000000;
	localparam logic [31:0] IDLE_RESET_RST  = 32'h00000000;

	// identification fields
	localparam int unsigned ID_REV_LSB  = 8;
	localparam int unsigned ID_MODE_LSB = 0;
	localparam logic [7:0]  MODE_TRANSMIT = 8'h00;
	localparam logic [7:0]  MODE_RECEIVE  = 8'h01;

	// transceiver status field positions
	localparam int unsigned ST_RESET_DONE_LSB = 0;
	localparam int unsigned ST_PLL_T0_BIT     = 4;
	localparam int unsigned ST_PLL_T1_BIT     = 5;
	localparam int unsigned ST_FABRIC_PLL_BIT = 6;
	localparam int unsigned ST_RXCLK_LOCK_BIT = 7;
	localparam int unsigned ST_PRBS_LSB       = 8;
	localparam int unsigned ST_VOLT_LOW_LSB   = 12;
	localparam int unsigned ST_ALIGN_LSB      = 16;
	localparam int unsigned ST_SYMLOCK_LSB    = 19;
	localparam int unsigned ST_RXBUF_LSB      = 24;

	// dma vertical sync length in clock cycles
	localparam int unsigned VSYNC_DMA_CYCLES = 255;

	typedef enum logic [1:0] {
		DPSS_VS_IDLE,
		DPSS_VS_DMA_PULSE
	} dpss_vs_state_type;

endpackage

// ---- hdl/dpss_sync.sv ----
`timescale 1ns/100ps
module dpss_sync
	import dpss_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

	initial begin
		if (WIDTH < 1) begin
			$error("dpss_sync: WIDTH must be at least 1");
		end
	end

endmodule

// ---- bench/dpss_regs_sva.sv ----
`timescale 1ns/100ps
module dpss_regs_chk
	import dpss_pkg::*;
(
	// bus
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	input wire logic [DATA_W-1:0] prdata_o,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	// controls
	input wire logic [DATA_W-1:0] link_rate_o,
	input wire logic [DATA_W-1:0] lane_count_o,
	input wire logic              phy_rx_reset_o
);
	logic tk;
	logic hit;
	assign tk = psel_i & penable_i & !pready_o;
	assign hit = paddr_i inside {ADDR_LINK_RATE, ADDR_LANE_COUNT, ADDR_BLOCK_ID,
		ADDR_FIFO_OVERRUN, ADDR_VSYNC_MON, ADDR_XCVR_RESET, ADDR_XCVR_STATUS, ADDR_IDLE_RESET};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	bus_answer_a: assert property (tk |=> pready_o) else $error("no answer");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
	ready_cause_a: assert property (pready_o |-> $past(tk)) else $error("ready uncaused");
	idle_data_a: assert property (!pready_o |-> prdata_o == '0 && !pslverr_o)
		else $error("data outside answer");
	unmapped_err_a: assert property (tk && !hit |=> pslverr_o && prdata_o == '0)
		else $error("unmapped not refused");
	mapped_ok_a: assert property (tk && hit |=> !pslverr_o) else $error("mapped refused");
	ident_mode_a: assert property (tk && !pwrite_i && paddr_i == ADDR_BLOCK_ID
		|=> prdata_o[7:0] == MODE_RECEIVE) else $error("wrong direction code");
	rate_write_a: assert property (tk && pwrite_i && paddr_i == ADDR_LINK_RATE
		|-> ##2 link_rate_o == $past(pwdata_i, 2)) else $error("rate not applied");
	lane_write_a: assert property (tk && pwrite_i && paddr_i == ADDR_LANE_COUNT
		|-> ##2 lane_count_o == $past(pwdata_i, 2)) else $error("lanes not applied");
	reset_hold_a: assert property ($rose(rst_n_i) |-> phy_rx_reset_o)
		else $error("phy not held after reset");
	hold_write_a: assert property (tk && pwrite_i && paddr_i == ADDR_XCVR_RESET
		&& pwdata_i[1:0] == XCVR_HOLD_CODE |-> ##2 phy_rx_reset_o) else $error("phy not held");
endmodule

bind dpss_regs dpss_regs_chk u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link_rate_o, .lane_count_o,
	.phy_rx_reset_o);

// ---- bench/dpss_regs_tb_top.sv ----
`timescale 1ns/100ps
module dpss_regs_tb_top
	import dpss_pkg::*;
;
	localparam int unsigned VSC = 20;
	localparam logic [31:0] ID_EXP = {8'h2A, 8'h3C, 8'h5D, MODE_RECEIVE};
	localparam logic [31:0] PAT = 32'hA5C3_6E19;
	typedef struct packed {
		logic        wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} dpss_row_type;
	logic        clk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
	logic        pwrite_i = 1'h0, phy_fabric_pll_lock_i = 1'h0, phy_rx_clk_lock_i = 1'h0;
	logic        phy_elec_idle_i = 1'h0, pix_fifo_ovf_toggle_i = 1'h0, vsync_level_i = 1'h0;
	logic        vsync_start_toggle_i = 1'h0, dma_mode_i = 1'h0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0]  transceiver_reset_control_done_i = 4'h0, phy_prbs_err_i = 4'h0, phy_volt_low_i = 4'h0;
	logic [3:0]  phy_lane_align_i = 4'h0, phy_symbol_lock_i = 4'h0;
	logic [1:0]  phy_tile_pll_lock_i = 2'h0;
	logic [7:0]  phy_rx_buf_status_i = 8'h0;
	logic [31:0] prdata_o, link_rate_o, lane_count_o, rd, r1, st;
	logic        pready_o, pslverr_o, phy_rx_reset_o, er;
	int          fail_count = 0;
	int          num_checks = 0;
	dpss_row_type rows [12];

	dpss_regs #(.PROTO_MAJOR(8'h2A), .PROTO_MINOR(8'h3C), .PROTO_REV(8'h5D),
		.VSYNC_CYCLES(VSC)) DUT (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .transceiver_reset_control_done_i,
		.phy_tile_pll_lock_i, .phy_fabric_pll_lock_i, .phy_rx_clk_lock_i, .phy_prbs_err_i,
		.phy_volt_low_i, .phy_lane_align_i, .phy_symbol_lock_i, .phy_rx_buf_status_i,
		.phy_elec_idle_i, .pix_fifo_ovf_toggle_i, .vsync_level_i, .vsync_start_toggle_i,
		.dma_mode_i, .link_rate_o, .lane_count_o, .phy_rx_reset_o);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until ready is sampled high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 8);
		chk(32'(pready_o), 32'h1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask

	task automatic note(input string s);
		$display("test %s done at %0t", s, $time);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	// full run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		rows = '{'{1'h0, ADDR_BLOCK_ID, '0, ID_EXP, 1'h0},
			'{1'h0, ADDR_XCVR_RESET, '0, XCVR_RESET_RST, 1'h0},
			'{1'h0, ADDR_LINK_RATE, '0, LINK_RATE_RST, 1'h0},
			'{1'h1, ADDR_LINK_RATE, 32'h14, '0, 1'h0},
			'{1'h0, ADDR_LINK_RATE, '0, 32'h14, 1'h0},
			'{1'h1, ADDR_LANE_COUNT, 32'h4, '0, 1'h0},
			'{1'h0, ADDR_LANE_COUNT, '0, 32'h4, 1'h0},
			'{1'h1, ADDR_BLOCK_ID, 32'hFFFF_FFFF, '0, 1'h0},
			'{1'h0, ADDR_BLOCK_ID, '0, ID_EXP, 1'h0},
			'{1'h0, ADDR_IDLE_RESET, '0, IDLE_RESET_RST, 1'h0},
			'{1'h0, 12'h300, '0, '0, 1'h1},
			'{1'h1, 12'h204, 32'h5, '0, 1'h1}};
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk(32'(phy_rx_reset_o), 32'h1);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].d);
			chk(rd, rows[i].q);
			chk(32'(er), 32'(rows[i].e));
		end
		chk(link_rate_o, 32'h14);
		chk(lane_count_o, 32'h4);
		note("table");
		// lanes 2 and 3 alignment are not shown
		for (int k = 0; k < 2; k++) begin
			st = k ? PAT : ~PAT;
			transceiver_reset_control_done_i <= st[3:0];
			phy_tile_pll_lock_i <= st[5:4];
			phy_fabric_pll_lock_i <= st[6];
			phy_rx_clk_lock_i <= st[7];
			phy_prbs_err_i <= st[11:8];
			phy_volt_low_i <= st[15:12];
			phy_lane_align_i <= {2'h3, st[17:16]};
			phy_symbol_lock_i <= st[22:19];
			phy_rx_buf_status_i <= st[31:24];
			repeat (4) @(posedge clk_i);
			bus(1'h0, ADDR_XCVR_STATUS, '0);
			chk(rd, st & ~32'h0084_0000);
		end
		note("status");
		// k = 0 lands the flag set on the clearing read
		for (int k = 0; k < 7; k++) begin
			pix_fifo_ovf_toggle_i <= ~pix_fifo_ovf_toggle_i;
			repeat (k) @(posedge clk_i);
			bus(1'h0, ADDR_FIFO_OVERRUN, '0);
			r1 = rd;
			if (k == 6) chk(r1, 32'h1);
			bus(1'h0, ADDR_FIFO_OVERRUN, '0);
			chk(32'(r1[0] | rd[0]), 32'h1);
			bus(1'h0, ADDR_FIFO_OVERRUN, '0);
			chk(rd, 32'h0);
		end
		note("overflow");
		for (int v = 1; v >= 0; v--) begin
			vsync_level_i <= 1'(v);
			repeat (5) @(posedge clk_i);
			bus(1'h0, ADDR_VSYNC_MON, '0);
			chk(rd, 32'(v));
		end
		dma_mode_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		// two pulses, reads one edge apart at both ends pin the length
		for (int p = 0; p < 2; p++) begin
			vsync_start_toggle_i <= ~vsync_start_toggle_i;
			repeat (p) @(posedge clk_i);
			bus(1'h0, ADDR_VSYNC_MON, '0);
			chk(rd, 32'(p));
			repeat (VSC - 4) @(posedge clk_i);
			bus(1'h0, ADDR_VSYNC_MON, '0);
			chk(rd, 32'(1 - p));
		end
		dma_mode_i <= 1'h0;
		note("vsync");
		rst_n_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk(link_rate_o, LINK_RATE_RST);
		bus(1'h0, ADDR_XCVR_RESET, '0);
		chk(rd, XCVR_RESET_RST);
		// overflow toggle stands high across this reset
		bus(1'h0, ADDR_FIFO_OVERRUN, '0);
		chk(rd, 32'h0);
		note("second reset");
		bus(1'h1, ADDR_XCVR_RESET, '0);
		repeat (2) @(posedge clk_i);
		chk(32'(phy_rx_reset_o), 32'h0);
		bus(1'h1, ADDR_IDLE_RESET, 32'h1);
		for (int v = 1; v >= 0; v--) begin
			phy_elec_idle_i <= 1'(v);
			repeat (5) @(posedge clk_i);
			chk(32'(phy_rx_reset_o), 32'(v));
		end
		bus(1'h1, ADDR_XCVR_RESET, 32'h3);
		repeat (2) @(posedge clk_i);
		chk(32'(phy_rx_reset_o), 32'h1);
		note("transceiver_reset_control");
		tally_and_finish();
	end
endmodule
